// file: core/eip_ext_irq.sv
/*
  External interrupt front end: one interrupt pin and falling-edge detectors on
  two 8-bit ports merged into one request to the CPU core, with a control/status
  register and an option register on AHB-Lite.
  Assumes the CPU core supplies its interrupt mask, a vector fetch strobe with
  address and a stop/wait strobe, all synchronous to hclk.
*/
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps

// Summary of operation
// - Request to CPU is blocked while the CPU interrupt mask is set.
// - Port sources see only falling edges of the AND of input pins.
// - Pin, port A and port C each latch; merged into one request.
// - Edge-only option: only a pin falling edge sets the pin flag.
// - Level option: a low pin level also sets the pin flag.
// - Each flag raises the request only while its own enable is set.
// - Service address comes from vector pair 3FFA/3FFB.
// - Vector fetch clears the pin latch and flag.
// - Vector fetch leaves port A and port C latches set.
// - Writing one to acknowledge clears all three latches; zero does nothing.
// - Acknowledge bit always reads zero.
// - Flags are read-only; only acknowledge clears them, and vector fetch also clears the pin flag.
// - Control/status register sits at 001F; unused bits read zero.
// - Reset clears flags, sets pin enable, clears port enables.
// - STOP or WAIT forces pin enable to one, port enables unchanged.
// - Pin flag sets only while pin enable is set.
// - Port flags capture falling edges whatever their enables.
// - Request stays asserted while any flag and its enable are set.
// - Branch-on-pin sees the raw pin level only.
// - Pin synchronised to the clock in two stages, then its falling edge latched.
module eip_ext_irq (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt pin and ports
  input wire logic irq_pin_n,
  input wire logic [7:0] porta_in,
  input wire logic [7:0] porta_dir,
  input wire logic [7:0] portc_in,
  input wire logic [7:0] portc_dir,
  // CPU core
  input wire logic cpu_int_mask,
  input wire logic cpu_fetch,
  input wire logic [15:0] cpu_fetch_addr,
  input wire logic cpu_stop_wait,
  output logic ext_irq_request,
  output logic [15:0] ext_irq_vector,
  output logic branch_pin_level
);
  import eip_pkg::*;

  eip_state_s st;
  eip_state_s next_st;

  // Direction bit high marks an output; outputs never take part in the AND
  function automatic logic port_and(input logic [7:0] pins, input logic [7:0] dir);
    port_and = &(pins | dir);
  endfunction : port_and

  function automatic logic addr_hit(input logic [31:0] addr, input logic [29:0] idx);
    addr_hit = (addr[31:2] == idx);
  endfunction : addr_hit

  logic pa_and;
  logic pc_and;
  logic pin_fall;
  logic pin_set;
  logic pa_set;
  logic pc_set;
  logic addr_phase;
  logic ack_now;
  logic ctl_write;
  logic opt_write;
  logic vec_fetch;

  assign pa_and = port_and(st.pa_s2, porta_dir);
  assign pc_and = port_and(st.pc_s2, portc_dir);
  assign pin_fall = st.pin_prev & ~st.pin_s2;
  // Pin events are ignored while the pin enable is clear
  assign pin_set = st.pin_request_enable & (pin_fall | (st.level_select & ~st.pin_s2));
  assign pa_set = st.pa_prev & ~pa_and;
  assign pc_set = st.pc_prev & ~pc_and;
  assign addr_phase = hsel & htrans[EIP_HTRANS_ACTIVE_BIT] & hready;
  assign ctl_write = st.dp_write & st.dp_ctl;
  assign opt_write = st.dp_write & st.dp_opt;
  assign ack_now = ctl_write & hwdata[EIP_ACK_BIT];
  assign vec_fetch = cpu_fetch & ((cpu_fetch_addr == EIP_VEC_HI) | (cpu_fetch_addr == EIP_VEC_LO));

  always_comb begin
    next_st = st;
    // Stage one feeds stage two only; all detection looks at stage two
    next_st.pin_s1 = irq_pin_n;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    next_st.pa_s1 = porta_in;
    next_st.pa_s2 = st.pa_s1;
    next_st.pa_prev = pa_and;
    next_st.pc_s1 = portc_in;
    next_st.pc_s2 = st.pc_s1;
    next_st.pc_prev = pc_and;

    // Clears first, sets after, so an event in the clearing cycle survives
    if (ack_now) begin
      next_st.pin_request_flag = 1'b0;
      next_st.porta_request_flag = 1'b0;
      next_st.portc_request_flag = 1'b0;
    end
    if (vec_fetch) begin
      next_st.pin_request_flag = 1'b0;
    end
    if (pin_set) begin
      next_st.pin_request_flag = 1'b1;
    end
    if (pa_set) begin
      next_st.porta_request_flag = 1'b1;
    end
    if (pc_set) begin
      next_st.portc_request_flag = 1'b1;
    end

    // Flag bit positions of the write data are not looked at
    if (ctl_write) begin
      next_st.pin_request_enable = hwdata[EIP_PIN_EN_BIT];
      next_st.porta_request_enable = hwdata[EIP_PA_EN_BIT];
      next_st.portc_request_enable = hwdata[EIP_PC_EN_BIT];
    end
    if (cpu_stop_wait) begin
      next_st.pin_request_enable = 1'b1;
    end
    if (opt_write) begin
      next_st.level_select = hwdata[EIP_LEVEL_BIT];
    end

    // Zero-wait slave: read data is built from the post-write state so a
    // read right behind a write sees the new value
    if (addr_phase) begin
      next_st.dp_write = hwrite;
      next_st.dp_ctl = addr_hit(haddr, EIP_CTL_IDX);
      next_st.dp_opt = addr_hit(haddr, EIP_OPT_IDX);
      next_st.hrdata = 32'h00000000;
      if (!hwrite && addr_hit(haddr, EIP_CTL_IDX)) begin
        next_st.hrdata[EIP_PIN_EN_BIT] = next_st.pin_request_enable;
        next_st.hrdata[EIP_PA_EN_BIT] = next_st.porta_request_enable;
        next_st.hrdata[EIP_PC_EN_BIT] = next_st.portc_request_enable;
        next_st.hrdata[EIP_ACK_BIT] = 1'b0;
        next_st.hrdata[EIP_PIN_FLAG_BIT] = next_st.pin_request_flag;
        next_st.hrdata[EIP_PA_FLAG_BIT] = next_st.porta_request_flag;
        next_st.hrdata[EIP_PC_FLAG_BIT] = next_st.portc_request_flag;
      end else if (!hwrite && addr_hit(haddr, EIP_OPT_IDX)) begin
        next_st.hrdata[EIP_LEVEL_BIT] = next_st.level_select;
      end
    end else if (hready) begin
      next_st.dp_write = 1'b0;
      next_st.dp_ctl = 1'b0;
      next_st.dp_opt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      // Idle pins sit high; starting high avoids a false edge after reset
      st.pin_s1 <= 1'b1;
      st.pin_s2 <= 1'b1;
      st.pin_prev <= 1'b1;
      st.pa_s1 <= 8'hff;
      st.pa_s2 <= 8'hff;
      st.pa_prev <= 1'b1;
      st.pc_s1 <= 8'hff;
      st.pc_s2 <= 8'hff;
      st.pc_prev <= 1'b1;
      st.pin_request_enable <= EIP_PIN_EN_RST;
      st.porta_request_enable <= EIP_PA_EN_RST;
      st.portc_request_enable <= EIP_PC_EN_RST;
      st.level_select <= EIP_LEVEL_RST;
    end else begin
      st <= next_st;
    end
  end

  // Holds while a flag and its enable stay set, until one is cleared
  assign ext_irq_request = ~cpu_int_mask &
    ((st.pin_request_flag & st.pin_request_enable) |
     (st.porta_request_flag & st.porta_request_enable) |
     (st.portc_request_flag & st.portc_request_enable));
  assign ext_irq_vector = EIP_VEC_HI;
  // Raw pin only; port sources never leak into the branch test
  assign branch_pin_level = st.pin_s2;
  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = EIP_HRESP_OKAY;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  mask_block_a: assert property (cpu_int_mask |-> !ext_irq_request)
    else $error("request passed while CPU mask set");

  port_fall_a: assert property ((st.pa_prev && !pa_and) |=> st.porta_request_flag)
    else $error("port A falling edge did not set its flag");

  portc_fall_a: assert property ((st.pc_prev && !pc_and) |=> st.portc_request_flag)
    else $error("port C falling edge did not set its flag");

  edge_only_a: assert property ((!st.level_select && !st.pin_request_flag && !pin_fall) |=>
    !st.pin_request_flag)
    else $error("pin flag set without a falling edge");

  level_set_a: assert property ((st.level_select && st.pin_request_enable && !st.pin_s2) |=>
    st.pin_request_flag)
    else $error("low pin level did not set pin flag");

  flag_gate_a: assert property ((!cpu_int_mask && st.porta_request_flag && st.porta_request_enable) |->
    ext_irq_request)
    else $error("enabled port A flag did not raise request");

  vec_clear_a: assert property ((vec_fetch && !pin_set) |=> !st.pin_request_flag)
    else $error("vector fetch left pin flag set");

  vec_keep_a: assert property ((vec_fetch && !ack_now && st.porta_request_flag && st.portc_request_flag) |=>
    (st.porta_request_flag && st.portc_request_flag))
    else $error("vector fetch cleared a port flag");

  ack_clear_a: assert property ((ack_now && !pin_set && !pa_set && !pc_set) |=>
    (!st.pin_request_flag && !st.porta_request_flag && !st.portc_request_flag))
    else $error("acknowledge did not clear the latches");

  ack_zero_a: assert property ((ctl_write && !hwdata[EIP_ACK_BIT] && !vec_fetch) |=>
    (st.porta_request_flag >= $past(st.porta_request_flag) &&
     st.pin_request_flag >= $past(st.pin_request_flag)))
    else $error("write without acknowledge cleared a flag");

  ack_read_a: assert property ((st.dp_ctl && !st.dp_write) |-> !hrdata[EIP_ACK_BIT])
    else $error("acknowledge bit read back as one");

  stop_wake_a: assert property ((cpu_stop_wait && !ctl_write) |=>
    (st.pin_request_enable && $stable(st.porta_request_enable) && $stable(st.portc_request_enable)))
    else $error("stop or wait did not force pin enable");

  pin_gate_a: assert property ((!st.pin_request_enable && !st.pin_request_flag) |=>
    !st.pin_request_flag)
    else $error("pin flag set while pin enable clear");

  req_hold_a: assert property ((ext_irq_request && !ack_now && !ctl_write && !vec_fetch && !cpu_int_mask)
    ##1 !cpu_int_mask |-> ext_irq_request)
    else $error("request dropped while flag and enable held");

  pin_sync_a: assert property ((!irq_pin_n && st.pin_request_enable && st.pin_s2 && st.pin_s1)
    ##1 (!irq_pin_n && st.pin_request_enable && !ctl_write) |=> (!ack_now && !vec_fetch) |=> st.pin_request_flag)
    else $error("held pin low was not latched after two stages");

  unused_zero_a: assert property ((st.dp_ctl && !st.dp_write) |-> (hrdata[31:8] == 24'h000000 && !hrdata[0]))
    else $error("unused control bits read non-zero");

  // Request merging and gating
  no_source_a: assert property (!((st.pin_request_flag && st.pin_request_enable) ||
    (st.porta_request_flag && st.porta_request_enable) || (st.portc_request_flag && st.portc_request_enable)) |->
    !ext_irq_request)
    else $error("request raised with no enabled flag");

  portc_gate_a: assert property ((!cpu_int_mask && st.portc_request_flag && st.portc_request_enable) |->
    ext_irq_request)
    else $error("enabled port C flag did not raise request");

  pin_req_a: assert property ((!cpu_int_mask && st.pin_request_flag && st.pin_request_enable) |->
    ext_irq_request)
    else $error("enabled pin flag did not raise request");

  merge_src_a: assert property (ext_irq_request |->
    (st.pin_request_flag || st.porta_request_flag || st.portc_request_flag))
    else $error("request raised with no flag set");

  // Flags persist until their own clear; port flags follow edges only
  pa_hold_a: assert property ((st.porta_request_flag && !ack_now) |=>
    st.porta_request_flag)
    else $error("port A flag cleared without acknowledge");

  pc_hold_a: assert property ((st.portc_request_flag && !ack_now) |=>
    st.portc_request_flag)
    else $error("port C flag cleared without acknowledge");

  pin_hold_a: assert property ((st.pin_request_flag && !ack_now && !vec_fetch) |=>
    st.pin_request_flag)
    else $error("pin flag cleared without acknowledge or fetch");

  pa_edge_a: assert property ((!st.porta_request_flag && !pa_set) |=>
    !st.porta_request_flag)
    else $error("port A flag set without a falling edge");

  pc_edge_a: assert property ((!st.portc_request_flag && !pc_set) |=>
    !st.portc_request_flag)
    else $error("port C flag set without a falling edge");

  pin_fall_a: assert property ((pin_fall && st.pin_request_enable) |=>
    st.pin_request_flag)
    else $error("enabled pin falling edge did not set pin flag");

  ack_pin_a: assert property ((ack_now && !pin_set) |=>
    !st.pin_request_flag)
    else $error("acknowledge left pin flag set");

  vec_lo_a: assert property ((cpu_fetch && (cpu_fetch_addr == EIP_VEC_LO) && !pin_set) |=>
    !st.pin_request_flag)
    else $error("second vector byte fetch left pin flag set");

  // Every detector looks two clocks behind its pin
  pin_depth_a: assert property (
    st.pin_s2 == $past(irq_pin_n, 2))
    else $error("pin synchroniser is not two stages deep");

  branch_raw_a: assert property (
    branch_pin_level == $past(irq_pin_n, 2))
    else $error("branch level does not follow the raw pin");

  pa_depth_a: assert property (
    st.pa_s2 == $past(porta_in, 2))
    else $error("port A synchroniser is not two stages deep");

  pc_depth_a: assert property (
    st.pc_s2 == $past(portc_in, 2))
    else $error("port C synchroniser is not two stages deep");

  // Enable and option writes; stop or wait outranks a written pin enable
  pin_en_wr_a: assert property ((ctl_write && !cpu_stop_wait) |=>
    (st.pin_request_enable == $past(hwdata[EIP_PIN_EN_BIT])))
    else $error("pin enable did not take the written value");

  pa_en_wr_a: assert property (ctl_write |=>
    (st.porta_request_enable == $past(hwdata[EIP_PA_EN_BIT])))
    else $error("port A enable did not take the written value");

  pc_en_wr_a: assert property (ctl_write |=>
    (st.portc_request_enable == $past(hwdata[EIP_PC_EN_BIT])))
    else $error("port C enable did not take the written value");

  stop_set_a: assert property (cpu_stop_wait |=>
    st.pin_request_enable)
    else $error("stop or wait lost against a register write");

  pin_en_keep_a: assert property ((!ctl_write && !cpu_stop_wait) |=>
    $stable(st.pin_request_enable))
    else $error("pin enable changed without write or stop");

  port_en_keep_a: assert property (!ctl_write |=>
    ($stable(st.porta_request_enable) && $stable(st.portc_request_enable)))
    else $error("port enable changed without a write");

  level_wr_a: assert property (opt_write |=>
    (st.level_select == $past(hwdata[EIP_LEVEL_BIT])))
    else $error("level select did not take the written value");

  // Register reads
  read_ack_a: assert property ((addr_phase && !hwrite) |=>
    !hrdata[EIP_ACK_BIT])
    else $error("read data shows acknowledge set");

  opt_read_a: assert property ((st.dp_opt && !st.dp_write) |->
    (hrdata[31:1] == 31'h00000000))
    else $error("unused option bits read non-zero");

  unmapped_read_a: assert property ((addr_phase && !hwrite && !addr_hit(haddr, EIP_CTL_IDX) &&
    !addr_hit(haddr, EIP_OPT_IDX)) |=> (hrdata == 32'h00000000))
    else $error("unmapped address read non-zero");

endmodule : eip_ext_irq

// file: core/eip_pkg.sv
/*
  Constants, register layout and state type of the external interrupt front end.
  Assumes a 32-bit AHB-Lite register bus and one 200 MHz clock.
*/
package eip_pkg;

  // Register indices; byte address is four times the index
  localparam logic [29:0] EIP_CTL_IDX = 30'h0000001f;
  localparam logic [29:0] EIP_OPT_IDX = 30'h00000020;

  // Field positions in ext_irq_control_status
  localparam int unsigned EIP_PIN_EN_BIT = 7;
  localparam int unsigned EIP_PA_EN_BIT = 6;
  localparam int unsigned EIP_PC_EN_BIT = 5;
  localparam int unsigned EIP_ACK_BIT = 4;
  localparam int unsigned EIP_PIN_FLAG_BIT = 3;
  localparam int unsigned EIP_PA_FLAG_BIT = 2;
  localparam int unsigned EIP_PC_FLAG_BIT = 1;

  // Field position in mask_option_register
  localparam int unsigned EIP_LEVEL_BIT = 0;

  // Reset values
  localparam logic EIP_PIN_EN_RST = 1'b1;
  localparam logic EIP_PA_EN_RST = 1'b0;
  localparam logic EIP_PC_EN_RST = 1'b0;
  localparam logic EIP_LEVEL_RST = 1'b0;

  // Service vector pair of the external interrupt
  localparam logic [15:0] EIP_VEC_HI = 16'h3ffa;
  localparam logic [15:0] EIP_VEC_LO = 16'h3ffb;

  // Bus encodings
  localparam int unsigned EIP_HTRANS_ACTIVE_BIT = 1;
  localparam logic EIP_HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic pa_prev;
    logic [7:0] pc_s1;
    logic [7:0] pc_s2;
    logic pc_prev;
    logic pin_request_flag;
    logic porta_request_flag;
    logic portc_request_flag;
    logic pin_request_enable;
    logic porta_request_enable;
    logic portc_request_enable;
    logic level_select;
    logic dp_write;
    logic dp_ctl;
    logic dp_opt;
    logic [31:0] hrdata;
  } eip_state_s;

endpackage : eip_pkg

// file: testbench/eip_cpu_model.sv
/*
  Stand-in for the CPU core interrupt sequencer facing the external interrupt block.
  Assumes hclk-synchronous signals; the bench clears the mask with a one-cycle cli pulse.
*/
`timescale 1ns/10ps
module eip_cpu_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Block side
  input wire logic ext_irq_request,
  input wire logic [15:0] ext_irq_vector,
  output logic cpu_int_mask,
  output logic cpu_fetch,
  output logic [15:0] cpu_fetch_addr,
  // Bench side
  input wire logic cli,
  output logic [7:0] serve_cnt
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_int_mask <= 1'h1;
      cpu_fetch <= 1'h0;
      cpu_fetch_addr <= 16'h0000;
      serve_cnt <= 8'h00;
    end else begin
      cpu_fetch <= 1'h0;
      // Second byte of the vector pair follows the first
      if (cpu_fetch && (cpu_fetch_addr == ext_irq_vector)) begin
        cpu_fetch <= 1'h1;
        cpu_fetch_addr <= ext_irq_vector + 16'h0001;
      end
      if (cli) begin
        cpu_int_mask <= 1'h0;
      end else if (ext_irq_request && !cpu_int_mask) begin
        // Stacking is skipped; the mask rises in the same cycle as the vector fetch
        cpu_int_mask <= 1'h1;
        cpu_fetch <= 1'h1;
        cpu_fetch_addr <= ext_irq_vector;
        serve_cnt <= serve_cnt + 8'h01;
      end
    end
  end
endmodule : eip_cpu_model

// file: testbench/tb_top.sv
/*
  Self-checking bench of the external interrupt front end with a CPU stand-in.
  Assumes the registers at byte addresses 0x7c and 0x80; waits on hreadyout are bounded.
*/
`timescale 1ns/10ps
module tb_top;
  import eip_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_pin_n, cli;
  logic cpu_int_mask, cpu_fetch, cpu_stop_wait, ext_irq_request, branch_pin_level;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] porta_in, porta_dir, portc_in, portc_dir, serve_cnt;
  logic [15:0] cpu_fetch_addr, ext_irq_vector;
  int error_cnt, checked;
  localparam logic [31:0] CTL = 32'h0000007c;
  localparam logic [31:0] OPT = 32'h00000080;
  assign hready = hreadyout;
  eip_ext_irq dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hrdata, .hreadyout, .hresp, .irq_pin_n, .porta_in, .porta_dir, .portc_in, .portc_dir,
    .cpu_int_mask, .cpu_fetch, .cpu_fetch_addr, .cpu_stop_wait, .ext_irq_request,
    .ext_irq_vector, .branch_pin_level);
  eip_cpu_model cpu (.hclk, .hresetn, .ext_irq_request, .ext_irq_vector, .cpu_int_mask,
    .cpu_fetch, .cpu_fetch_addr, .cli, .serve_cnt);
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 64) begin
        error_cnt++;
        complete_run;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  // Must be entered just after a rising edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    // hsel stays up between transfers; htrans IDLE marks the gaps
    rd = hrdata;
  endtask : bus
  task rdchk(input logic [31:0] a, input logic [31:0] exp, input string name);
    bus(1'h0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk
  // One cli pulse, then time for a service to happen
  task unmask;
    cli <= 1'h1;
    cyc(1);
    cli <= 1'h0;
    cyc(5);
  endtask : unmask
  task t_reset;
    rdchk(CTL, 32'h80, "ctl reset");
    rdchk(OPT, 32'h0, "opt reset");
    rdchk(32'h84, 32'h0, "unmapped");
    chk("pin level idle", 32'h1, {31'h0, branch_pin_level});
    chk("response okay", 32'h0, {31'h0, hresp});
    $display("test reset done");
  endtask : t_reset
  task t_pin;
    irq_pin_n <= 1'h0;
    cyc(5);
    chk("pin level low", 32'h0, {31'h0, branch_pin_level});
    chk("masked request", 32'h0, {31'h0, ext_irq_request});
    irq_pin_n <= 1'h1;
    bus(1'h1, CTL, 32'h8e);
    rdchk(CTL, 32'h88, "flag write");
    unmask;
    rdchk(CTL, 32'h80, "fetch clears pin");
    chk("vector", 32'h3ffa, {16'h0, ext_irq_vector});
    chk("vector low", 32'h3ffb, {16'h0, cpu_fetch_addr});
    chk("serves", 32'h1, {24'h0, serve_cnt});
    $display("test pin done");
  endtask : t_pin
  task t_port;
    bus(1'h1, CTL, 32'hc0);
    portc_in <= 8'hfe;
    cyc(5);
    rdchk(CTL, 32'hc2, "disabled port flag");
    unmask;
    chk("gated by enable", 32'h1, {24'h0, serve_cnt});
    porta_dir <= 8'hf0;
    porta_in <= 8'h7f;
    cyc(5);
    rdchk(CTL, 32'hc2, "output pin ignored");
    porta_in <= 8'h7b;
    cyc(5);
    chk("port served", 32'h2, {24'h0, serve_cnt});
    rdchk(CTL, 32'hc6, "port flags kept");
    chk("pin only level", 32'h1, {31'h0, branch_pin_level});
    unmask;
    chk("reentry", 32'h3, {24'h0, serve_cnt});
    porta_in <= 8'hff;
    portc_in <= 8'hff;
    bus(1'h1, CTL, 32'hd0);
    rdchk(CTL, 32'hc0, "acknowledge");
    $display("test port done");
  endtask : t_port
  task t_stop;
    bus(1'h1, CTL, 32'h60);
    irq_pin_n <= 1'h0;
    cyc(5);
    rdchk(CTL, 32'h60, "pin disabled");
    cpu_stop_wait <= 1'h1;
    cyc(1);
    cpu_stop_wait <= 1'h0;
    cyc(3);
    rdchk(CTL, 32'he0, "stop wait");
    $display("test stop done");
  endtask : t_stop
  task t_level;
    rdchk(CTL, 32'he0, "edge only");
    bus(1'h1, OPT, 32'h1);
    cyc(4);
    rdchk(CTL, 32'he8, "low level");
    irq_pin_n <= 1'h1;
    cyc(4);
    bus(1'h1, CTL, 32'hf0);
    rdchk(CTL, 32'he0, "level ack");
    bus(1'h1, OPT, 32'h0);
    $display("test level done");
  endtask : t_level
  initial begin
    error_cnt = 0;
    checked = 0;
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    irq_pin_n = 1'h1;
    porta_in = 8'hff;
    porta_dir = 8'h00;
    portc_in = 8'hff;
    portc_dir = 8'h00;
    cpu_stop_wait = 1'h0;
    cli = 1'h0;
    cyc(5);
    hresetn <= 1'h1;
    cyc(1);
    t_reset;
    t_pin;
    t_port;
    t_stop;
    t_level;
    complete_run;
  end
endmodule : tb_top
